/* File: hw/usbc_pkg.sv */
package usbc_pkg;

  // ***************************************************
  // register port geometry
  // ***************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ***************************************************
  // register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] REG_TICK_COUNT = 8'h00; // minislot_tick_count
  localparam logic [7:0] REG_CHANGE_AT = 8'h04; // change_effective_minislot
  localparam logic [7:0] REG_RX_LEVEL = 8'h08; // target_receive_level
  localparam logic [7:0] REG_IUC_SEL = 8'h0c; // profile accessed by burst window
  localparam logic [7:0] REG_STATUS = 8'h10; // reject flag, change pending
  localparam logic [7:0] REG_SSTR_LEN = 8'h14; // superstring length in bits
  localparam logic [7:0] SSTR_BASE = 8'h40; // superstring words, lsb word first
  localparam logic [7:0] BURST_BASE = 8'h80; // per-burst field window

  // ***************************************************
  // per-burst field indices inside the burst window
  // ***************************************************
  localparam logic [3:0] F_DIFF = 4'h0;
  localparam logic [3:0] F_RS_T = 4'h1;
  localparam logic [3:0] F_RS_K = 4'h2;
  localparam logic [3:0] F_PRE_LEN = 4'h3;
  localparam logic [3:0] F_PRE_OFF = 4'h4;
  localparam logic [3:0] F_PRE_MOD = 4'h5;
  localparam logic [3:0] F_SCR_EN = 4'h6;
  localparam logic [3:0] F_SEED = 4'h7;
  localparam logic [3:0] F_MAX_BURST = 4'h8;
  localparam logic [3:0] F_TRIM = 4'h9;
  localparam int NUM_FIELDS = 10;
  localparam int NUM_IUC = 16;

  // ***************************************************
  // value limits and encodings
  // ***************************************************
  localparam int SSTR_WORDS = 6;
  localparam logic [31:0] SSTR_MAX_BITS = 32'h0000_00c0; // 128 + 64
  localparam logic [31:0] IUC_MIN = 32'h0000_0001;
  localparam logic [31:0] IUC_MAX = 32'h0000_000e;
  localparam logic [31:0] BOOL_MAX = 32'h0000_0001;
  localparam logic [31:0] RS_T_MAX = 32'h0000_0010;
  localparam logic [31:0] RS_K_MIN = 32'h0000_0010;
  localparam logic [31:0] RS_K_MAX = 32'h0000_00fd;
  localparam logic [31:0] MOD_VARIANT_A = 32'h0000_0001;
  localparam logic [31:0] MOD_VARIANT_B = 32'h0000_0002;
  localparam logic [31:0] BYTE_MAX = 32'h0000_00ff;
  localparam logic [31:0] HALF_MAX = 32'h0000_ffff;

  // ***************************************************
  // status bits and reset values
  // ***************************************************
  localparam int ST_REJECT = 0;
  localparam int ST_PENDING = 1;
  localparam logic [3:0] IUC_SEL_RST = 4'h1;
  localparam logic [15:0] FIELD_RST = 16'h0000;
  localparam logic [15:0] RS_K_RST = 16'h0010;
  localparam logic [15:0] PRE_MOD_RST = 16'h0001;

  // address falls in the burst field window; returns field index or all ones
  function automatic logic [3:0] usbc_field_of(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - BURST_BASE;
    if (addr >= BURST_BASE && rel[1:0] == 2'b00 && rel[7:2] < 6'(NUM_FIELDS)) begin
      return rel[5:2];
    end
    return 4'hf;
  endfunction

endpackage

/* File: hw/usbc_value_check.sv */
`timescale 1ns/1ps
module usbc_value_check
  import usbc_pkg::*;
(
  input wire logic [7:0] addr_i,
  input wire logic [31:0] data_i,
  output logic ok_o
);

  // ***************************************************
  // range check of a written value by destination
  // ***************************************************
  logic [3:0] field;
  assign field = usbc_field_of(addr_i);

  // decide whether the write may be stored
  always_comb begin
    ok_o = 1'b1;
    if (addr_i == REG_IUC_SEL) begin
      ok_o = data_i >= IUC_MIN && data_i <= IUC_MAX; // [RULE6] [RULE17]
    end else if (addr_i == REG_SSTR_LEN) begin
      ok_o = data_i <= SSTR_MAX_BITS; // [RULE4] [RULE17]
    end else if (addr_i == REG_RX_LEVEL) begin
      ok_o = data_i <= HALF_MAX;
    end else begin
      case (field)
        F_DIFF, F_SCR_EN, F_TRIM: ok_o = data_i <= BOOL_MAX; // [RULE7] [RULE13] [RULE16] [RULE17]
        F_RS_T: ok_o = data_i <= RS_T_MAX; // [RULE8] [RULE17]
        F_RS_K: ok_o = data_i >= RS_K_MIN && data_i <= RS_K_MAX; // [RULE9] [RULE17]
        F_PRE_MOD: ok_o = data_i == MOD_VARIANT_A || data_i == MOD_VARIANT_B; // [RULE12] [RULE17]
        F_MAX_BURST: ok_o = data_i <= BYTE_MAX; // [RULE15]
        F_PRE_LEN, F_PRE_OFF, F_SEED: ok_o = data_i <= HALF_MAX; // [RULE10] [RULE11]
        default: ok_o = 1'b1;
      endcase
    end
  end

endmodule

/* File: hw/usbc_config_store.sv */
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// (RULE1) minislot size kept as 32-bit count of 6.25 ms ticks, read and write.
// (RULE2) written 32-bit minislot value; staged channel settings apply when counter matches it.
// (RULE3) reading the change-over minislot register always returns zero.
// (RULE4) preamble superstring up to 192 bits accepted, length register bounds it.
// (RULE5) target receive level stored as 16 bits in tenths of dBmV.
// (RULE6) burst code is one byte, only 1 to 14 valid.
// (RULE7) differential encoding off for 0, on for 1, per burst profile.
// (RULE8) Reed-Solomon correction 0 to 16; 0 means no error correction.
// (RULE9) codeword information bytes must lie between 16 and 253.
// (RULE10) preamble length held as unsigned 16-bit bit count per profile.
// (RULE11) preamble bits taken from superstring starting at 16-bit offset.
// (RULE12) preamble modulation: 1 first QPSK variant, 2 second; others reserved.
// (RULE13) scrambler off for 0, on for 1, per burst profile.
// (RULE14) only upper 15 bits of 16-bit scrambler seed are used.
// (RULE15) each burst limited to stored one-byte minislot maximum.
// (RULE16) final codeword: 0 fixed, 1 shortened; others reserved.
// (RULE17) out-of-range or reserved writes are dropped, old setting kept.
// (RULE18) one parameter set per valid burst code, selected by burst code.
module usbc_config_store
  import usbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [31:0] minislot_count_i,
  input wire logic [3:0] burst_iuc_i,
  input wire logic [15:0] preamble_bit_idx_i,
  output logic [31:0] minislot_tick_count_o,
  output logic [15:0] target_receive_level_o,
  output logic change_pending_o,
  output logic burst_iuc_valid_o,
  output logic diff_encode_enable_o,
  output logic fec_enable_o,
  output logic [4:0] rs_correctable_bytes_o,
  output logic [7:0] rs_info_byte_count_o,
  output logic [15:0] preamble_bit_length_o,
  output logic [15:0] preamble_start_bit_o,
  output logic preamble_qpsk_variant_b_o,
  output logic scramble_enable_o,
  output logic [14:0] scramble_init_value_o,
  output logic [7:0] burst_minislot_limit_o,
  output logic final_codeword_trim_o,
  output logic preamble_bit_o
);

  // ***************************************************
  // state
  // ***************************************************
  logic [31:0] tick_reg, tick_next, tick_act_reg, tick_act_next;
  logic [15:0] lvl_reg, lvl_next, lvl_act_reg, lvl_act_next;
  logic [31:0] chg_reg, chg_next;
  logic pend_reg, pend_next, rej_reg, rej_next;
  logic [3:0] sel_reg, sel_next;
  logic [7:0] slen_reg, slen_next;
  logic [SSTR_WORDS*32-1:0] sstr_reg, sstr_next;
  logic [15:0] prof_reg [NUM_IUC][NUM_FIELDS];
  logic [15:0] prof_next [NUM_IUC][NUM_FIELDS];
  logic [31:0] rdata_reg, rdata_next;
  logic val_ok, apply_now;
  logic [3:0] wfield, rfield;

  // ***************************************************
  // write path
  // ***************************************************
  usbc_value_check u_check (
    .addr_i(reg_addr_i),
    .data_i(reg_wdata_i),
    .ok_o(val_ok)
  );

  assign wfield = usbc_field_of(reg_addr_i);
  assign rfield = usbc_field_of(reg_addr_i);
  assign apply_now = pend_reg && (minislot_count_i == chg_reg); // [RULE2]

  // next values of all software-visible storage
  always_comb begin
    tick_next = tick_reg;
    lvl_next = lvl_reg;
    chg_next = chg_reg;
    pend_next = pend_reg;
    rej_next = rej_reg;
    sel_next = sel_reg;
    slen_next = slen_reg;
    sstr_next = sstr_reg;
    prof_next = prof_reg;
    tick_act_next = tick_act_reg;
    lvl_act_next = lvl_act_reg;
    if (apply_now) begin
      tick_act_next = tick_reg; // [RULE2]
      lvl_act_next = lvl_reg;
      pend_next = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[ST_REJECT]) begin
      rej_next = 1'b0;
    end
    if (reg_wr_i && !val_ok) begin
      rej_next = 1'b1; // [RULE17] set wins over clear
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_TICK_COUNT: tick_next = reg_wdata_i; // [RULE1]
        REG_RX_LEVEL: lvl_next = reg_wdata_i[15:0]; // [RULE5]
        REG_CHANGE_AT: begin
          chg_next = reg_wdata_i; // [RULE2]
          pend_next = 1'b1;
        end
        REG_IUC_SEL: sel_next = reg_wdata_i[3:0]; // [RULE6]
        REG_SSTR_LEN: slen_next = reg_wdata_i[7:0]; // [RULE4]
        default: begin
          for (int w = 0; w < SSTR_WORDS; w++) begin
            if (reg_addr_i == SSTR_BASE + 8'(4 * w)) begin
              sstr_next[w*32 +: 32] = reg_wdata_i; // [RULE4]
            end
          end
          if (wfield != 4'hf) begin
            prof_next[sel_reg][wfield] = reg_wdata_i[15:0]; // [RULE18]
          end
        end
      endcase
    end
  end

  // register the storage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_reg <= '0;
      lvl_reg <= '0;
      tick_act_reg <= '0;
      lvl_act_reg <= '0;
      chg_reg <= '0;
      pend_reg <= 1'b0;
      rej_reg <= 1'b0;
      sel_reg <= IUC_SEL_RST;
      slen_reg <= '0;
      sstr_reg <= '0;
      for (int i = 0; i < NUM_IUC; i++) begin
        for (int f = 0; f < NUM_FIELDS; f++) begin
          prof_reg[i][f] <= (f == F_RS_K) ? RS_K_RST : ((f == F_PRE_MOD) ? PRE_MOD_RST : FIELD_RST);
        end
      end
    end else begin
      tick_reg <= tick_next;
      lvl_reg <= lvl_next;
      tick_act_reg <= tick_act_next;
      lvl_act_reg <= lvl_act_next;
      chg_reg <= chg_next;
      pend_reg <= pend_next;
      rej_reg <= rej_next;
      sel_reg <= sel_next;
      slen_reg <= slen_next;
      sstr_reg <= sstr_next;
      prof_reg <= prof_next;
    end
  end

  // ***************************************************
  // read path
  // ***************************************************
  // read data for the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_TICK_COUNT: rdata_next = tick_reg; // [RULE1]
        REG_CHANGE_AT: rdata_next = '0; // [RULE3]
        REG_RX_LEVEL: rdata_next = {16'h0000, lvl_reg};
        REG_IUC_SEL: rdata_next = {28'h0000000, sel_reg};
        REG_STATUS: rdata_next = {30'h0, pend_reg, rej_reg};
        REG_SSTR_LEN: rdata_next = {24'h000000, slen_reg};
        default: begin
          for (int w = 0; w < SSTR_WORDS; w++) begin
            if (reg_addr_i == SSTR_BASE + 8'(4 * w)) begin
              rdata_next = sstr_reg[w*32 +: 32];
            end
          end
          if (rfield != 4'hf) begin
            rdata_next = {16'h0000, prof_reg[sel_reg][rfield]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ***************************************************
  // burst profile selection
  // ***************************************************
  logic iuc_ok;
  logic [15:0] sel_prof [NUM_FIELDS];
  logic [16:0] bit_pos;
  logic pre_bit_next, pre_bit_reg;
  logic [15:0] out_reg [NUM_FIELDS];
  logic iuc_ok_reg;

  assign iuc_ok = burst_iuc_i >= IUC_MIN[3:0] && burst_iuc_i <= IUC_MAX[3:0]; // [RULE6]

  // gather the set that belongs to the current burst code
  always_comb begin
    for (int f = 0; f < NUM_FIELDS; f++) begin
      sel_prof[f] = iuc_ok ? prof_reg[burst_iuc_i][f] : FIELD_RST; // [RULE18]
    end
    bit_pos = {1'b0, prof_reg[burst_iuc_i][F_PRE_OFF]} + {1'b0, preamble_bit_idx_i}; // [RULE11]
    pre_bit_next = 1'b0;
    if (iuc_ok && bit_pos < {9'h000, slen_reg}) begin
      pre_bit_next = sstr_reg[bit_pos[7:0]];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        out_reg[f] <= '0;
      end
      pre_bit_reg <= 1'b0;
      iuc_ok_reg <= 1'b0;
    end else begin
      out_reg <= sel_prof;
      pre_bit_reg <= pre_bit_next;
      iuc_ok_reg <= iuc_ok;
    end
  end

  // active settings, status, preamble bit and profile field outputs
  assign minislot_tick_count_o = tick_act_reg;
  assign target_receive_level_o = lvl_act_reg;
  assign change_pending_o = pend_reg;
  assign burst_iuc_valid_o = iuc_ok_reg;
  assign diff_encode_enable_o = out_reg[F_DIFF][0]; // [RULE7]
  assign rs_correctable_bytes_o = out_reg[F_RS_T][4:0]; // [RULE8]
  assign fec_enable_o = out_reg[F_RS_T] != 16'h0000; // [RULE8]
  assign rs_info_byte_count_o = out_reg[F_RS_K][7:0]; // [RULE9]
  assign preamble_bit_length_o = out_reg[F_PRE_LEN]; // [RULE10]
  assign preamble_start_bit_o = out_reg[F_PRE_OFF]; // [RULE11]
  assign preamble_qpsk_variant_b_o = out_reg[F_PRE_MOD] == MOD_VARIANT_B[15:0]; // [RULE12]
  assign scramble_enable_o = out_reg[F_SCR_EN][0]; // [RULE13]
  assign scramble_init_value_o = out_reg[F_SEED][15:1]; // [RULE14]
  assign burst_minislot_limit_o = out_reg[F_MAX_BURST][7:0]; // [RULE15]
  assign final_codeword_trim_o = out_reg[F_TRIM][0]; // [RULE16]
  assign preamble_bit_o = pre_bit_reg;

  // ***************************************************
  // assertions
  // ***************************************************
  property p_chg_reads_zero;
    @(posedge sys_clk_i) disable iff (rst_i) reg_rd_i && reg_addr_i == REG_CHANGE_AT |=> reg_rdata_o == 32'h0;
  endproperty
  a_chg_reads_zero: assert property (p_chg_reads_zero) else $error("change minislot read not zero"); // [RULE3]

  property p_tick_readback;
    @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == REG_TICK_COUNT ##1 reg_rd_i && reg_addr_i == REG_TICK_COUNT
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_tick_readback: assert property (p_tick_readback) else $error("tick count readback wrong"); // [RULE1]

  property p_apply_on_match;
    @(posedge sys_clk_i) disable iff (rst_i)
      pend_reg && minislot_count_i == chg_reg && !(reg_wr_i && reg_addr_i == REG_CHANGE_AT)
      |=> minislot_tick_count_o == $past(tick_reg) && !change_pending_o;
  endproperty
  a_apply_on_match: assert property (p_apply_on_match) else $error("change not applied at minislot"); // [RULE2]

  property p_hold_until_match;
    @(posedge sys_clk_i) disable iff (rst_i) !apply_now |=> $stable(minislot_tick_count_o);
  endproperty
  a_hold_until_match: assert property (p_hold_until_match) else $error("active size changed early"); // [RULE2]

  property p_bad_iuc_kept;
    @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == REG_IUC_SEL && (reg_wdata_i < IUC_MIN || reg_wdata_i > IUC_MAX)
      |=> $stable(sel_reg) && rej_reg;
  endproperty
  a_bad_iuc_kept: assert property (p_bad_iuc_kept) else $error("reserved burst code stored"); // [RULE6]

  property p_sel_range;
    @(posedge sys_clk_i) disable iff (rst_i) sel_reg >= 4'h1 && sel_reg <= 4'he;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selected burst code out of range"); // [RULE17]

  property p_rs_k_bounds;
    @(posedge sys_clk_i) disable iff (rst_i) burst_iuc_valid_o |-> rs_info_byte_count_o >= 8'h10 && rs_info_byte_count_o <= 8'hfd;
  endproperty
  a_rs_k_bounds: assert property (p_rs_k_bounds) else $error("codeword bytes out of range"); // [RULE9]

  property p_fec_flag;
    @(posedge sys_clk_i) disable iff (rst_i) fec_enable_o == (rs_correctable_bytes_o != 5'h00) && rs_correctable_bytes_o <= 5'h10;
  endproperty
  a_fec_flag: assert property (p_fec_flag) else $error("fec flag or t value wrong"); // [RULE8]

  property p_seed_drop_lsb;
    @(posedge sys_clk_i) disable iff (rst_i) iuc_ok |=> scramble_init_value_o == $past(prof_reg[burst_iuc_i][F_SEED][15:1]);
  endproperty
  a_seed_drop_lsb: assert property (p_seed_drop_lsb) else $error("seed bits misaligned"); // [RULE14]

  property p_sstr_len;
    @(posedge sys_clk_i) disable iff (rst_i) slen_reg <= 8'hc0;
  endproperty
  a_sstr_len: assert property (p_sstr_len) else $error("superstring length above maximum"); // [RULE4]

  c_apply: cover property (@(posedge sys_clk_i) disable iff (rst_i) apply_now);
  c_reject: cover property (@(posedge sys_clk_i) disable iff (rst_i) reg_wr_i && !val_ok);
  c_shortened: cover property (@(posedge sys_clk_i) disable iff (rst_i) burst_iuc_valid_o && final_codeword_trim_o);
  c_variant_b: cover property (@(posedge sys_clk_i) disable iff (rst_i) preamble_qpsk_variant_b_o && scramble_enable_o);

endmodule

/* File: dv/usbc_ctrl_model.sv */
`timescale 1ns/1ps
// ***********************************************
// core controller side of the register port
// ***********************************************
module usbc_ctrl_model
  import usbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [31:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // idle bus at time zero
  initial begin
    reg_addr_o = 8'hff;
    reg_wdata_o = 32'ha5a5_5a5a;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // one-cycle write; caller keeps codes 1..14 and 16..253 bytes unless testing refusal
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
    reg_addr_o <= ~a;
  endtask

  // write then read of the same address with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    @(posedge sys_clk_i);
    q = reg_rdata_i;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge sys_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

/* File: dv/us_scqam_burst_config_store_tb_top.sv */
`timescale 1ns/1ps
module us_scqam_burst_config_store_tb_top;
  import usbc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} usbc_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd;
  logic [31:0] ms_cnt = 32'h0;
  logic [3:0] iuc = 4'h1;
  logic [15:0] bit_idx = 16'h0;
  logic [31:0] size_o, p3 [10];
  logic [15:0] lvl_o, plen_o, poff_o;
  logic pend_o, val_o, diff_o, fec_o, varb_o, scr_o, trim_o, pbit_o;
  logic [4:0] rst_o;
  logic [7:0] rsk_o, lim_o;
  logic [14:0] seed_o;
  int err_total = 0;
  int n_compared = 0;
  usbc_row_t rows [28] = '{
    '{8'h00, 32'h1234, 32'h1234}, '{8'h04, 32'hffff_0000, 32'h0}, '{8'h08, 32'hff38, 32'hff38},
    '{8'h08, 32'h1_0000, 32'hff38}, '{8'h14, 32'hc0, 32'hc0}, '{8'h14, 32'hc1, 32'hc0},
    '{8'h80, 32'h1, 32'h1}, '{8'h80, 32'h2, 32'h1}, '{8'h84, 32'h10, 32'h10}, '{8'h84, 32'h11, 32'h10},
    '{8'h88, 32'hfd, 32'hfd}, '{8'h88, 32'hfe, 32'hfd}, '{8'h88, 32'hf, 32'hfd},
    '{8'h8c, 32'hffff, 32'hffff}, '{8'h90, 32'h123, 32'h123}, '{8'h94, 32'h2, 32'h2},
    '{8'h94, 32'h3, 32'h2}, '{8'h94, 32'h0, 32'h2}, '{8'h98, 32'h1, 32'h1}, '{8'h98, 32'h2, 32'h1},
    '{8'ha0, 32'hff, 32'hff}, '{8'ha0, 32'h100, 32'hff}, '{8'ha4, 32'h1, 32'h1}, '{8'ha4, 32'h2, 32'h1},
    '{8'hb0, 32'h5, 32'h0}, '{8'h0c, 32'hf, 32'h1}, '{8'h54, 32'hdead_beef, 32'hdead_beef},
    '{8'h9c, 32'h1_0000, 32'h0}};

  // ***********************************************
  // clock, design and controller model
  // ***********************************************
  always #10 sys_clk_i = ~sys_clk_i;

  usbc_config_store usbc_config_store_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .minislot_count_i(ms_cnt),
    .burst_iuc_i(iuc), .preamble_bit_idx_i(bit_idx), .minislot_tick_count_o(size_o),
    .target_receive_level_o(lvl_o), .change_pending_o(pend_o), .burst_iuc_valid_o(val_o),
    .diff_encode_enable_o(diff_o), .fec_enable_o(fec_o), .rs_correctable_bytes_o(rst_o),
    .rs_info_byte_count_o(rsk_o), .preamble_bit_length_o(plen_o), .preamble_start_bit_o(poff_o),
    .preamble_qpsk_variant_b_o(varb_o), .scramble_enable_o(scr_o), .scramble_init_value_o(seed_o),
    .burst_minislot_limit_o(lim_o), .final_codeword_trim_o(trim_o), .preamble_bit_o(pbit_o));

  usbc_ctrl_model usbc_ctrl_model_inst (
    .sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

  // ***********************************************
  // compare, settle and closing helpers
  // ***********************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    p3 = '{32'h1, 32'h0, 32'h64, 32'h8, 32'h4, 32'h2, 32'h1, 32'habcd, 32'h40, 32'h1};
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle();
    chk(32'(rsk_o), 32'h10);
    chk({val_o, pend_o, size_o[29:0]}, 32'h8000_0000);
    usbc_ctrl_model_inst.rd(REG_IUC_SEL, rv);
    chk(rv, 32'h1);
    $display("reset test done");
    // write then read-back cases, accepted and refused writes, selector 1
    foreach (rows[i]) begin
      usbc_ctrl_model_inst.wr_rd(rows[i].a, rows[i].d, rv);
      chk(rv, rows[i].e);
    end
    $display("register table test done");
    // profile 3 and profile 5 hold different settings
    usbc_ctrl_model_inst.wr(REG_IUC_SEL, 32'h3);
    for (int f = 0; f < NUM_FIELDS; f++) begin
      usbc_ctrl_model_inst.wr(BURST_BASE + 8'(f * 4), p3[f]);
    end
    usbc_ctrl_model_inst.wr(REG_IUC_SEL, 32'h5);
    usbc_ctrl_model_inst.wr(8'h80, 32'h0);
    usbc_ctrl_model_inst.wr(8'h84, 32'h5);
    @(posedge sys_clk_i);
    iuc <= 4'h3;
    settle();
    chk({31'h0, val_o}, 32'h1);
    chk({30'h0, diff_o, fec_o}, 32'h2);
    chk({rsk_o, lim_o, 11'h0, rst_o}, 32'h6440_0000);
    chk({plen_o, poff_o}, 32'h0008_0004);
    chk({29'h0, varb_o, scr_o, trim_o}, 32'h7);
    chk(32'(seed_o), 32'h55e6);
    @(posedge sys_clk_i);
    iuc <= 4'h5;
    settle();
    chk({26'h0, diff_o, fec_o, 4'h0} | 32'(rst_o), 32'h15);
    chk(32'(rsk_o), 32'h10);
    for (int c = 0; c < 2; c++) begin
      @(posedge sys_clk_i);
      iuc <= (c == 0) ? 4'h0 : 4'hf;
      settle();
      chk({val_o, diff_o, trim_o, 5'h0, rsk_o, lim_o, 8'h0}, 32'h0);
    end
    $display("burst profile test done");
    // preamble bits: superstring of 8 bits, profile 3 offset 4
    usbc_ctrl_model_inst.wr(REG_SSTR_LEN, 32'h8);
    usbc_ctrl_model_inst.wr(SSTR_BASE, 32'h0000_01f0);
    @(posedge sys_clk_i);
    iuc <= 4'h3;
    bit_idx <= 16'h0;
    settle();
    chk({31'h0, pbit_o}, 32'h1);
    @(posedge sys_clk_i);
    bit_idx <= 16'h3;
    settle();
    chk({31'h0, pbit_o}, 32'h1);
    @(posedge sys_clk_i);
    bit_idx <= 16'h4;
    settle();
    chk({31'h0, pbit_o}, 32'h0);
    $display("preamble test done");
    // sticky reject flag, then change-over with a replaced target
    usbc_ctrl_model_inst.rd(REG_STATUS, rv);
    chk(rv, 32'h3);
    usbc_ctrl_model_inst.wr(REG_STATUS, 32'h1);
    usbc_ctrl_model_inst.rd(REG_STATUS, rv);
    chk(rv, 32'h2);
    chk(size_o, 32'h0);
    usbc_ctrl_model_inst.wr(REG_CHANGE_AT, 32'h100);
    @(posedge sys_clk_i);
    ms_cnt <= 32'hffff_0000;
    settle();
    chk({31'h0, pend_o}, 32'h1);
    @(posedge sys_clk_i);
    ms_cnt <= 32'h100;
    settle();
    chk(size_o, 32'h1234);
    chk({pend_o, 15'h0, lvl_o}, 32'hff38);
    $display("change-over test done");
    // second reset in mid-run
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({size_o[30:0], pend_o}, 32'h0);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    usbc_ctrl_model_inst.rd(8'h88, rv);
    chk(rv, 32'h10);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
